/* File: pkg/power_pin_config_defines.vh */
// Constants for the power and pin control register bank.
// Assumes the includer uses them against an 8-bit configuration bus.
//
// Functional notes
// - Power and pin control register at index 06h clears to zero on reset.
// - Bit 0 floats IDE chip selects, blocks data bit 7 when IDE off.
// - Bit 1 floats floppy outputs, blocks inputs except disk change.
// - Bit 2 floats a down UART; its inputs read as ones.
// - Bit 3 clear: DMA acknowledge reads 1, DMA request floats.
// - Bit 4 swaps two pins between drive 1 and idle/power-down.
// - Bit 5 selective lock, set-only, protects itself and clock halving bit.
// - Global lock still locks all; selective lock only some bits.
// - Bit 6 floats parallel port outputs, blocks inputs to fixed values.
// - Clock/status register resets to zeros except strap and status bits.
// - Clock halving bit divides module clocks by two, latched from strap.
// - Bit 1 with halving gives floppy the undivided clock.
// - Bit 2 gates the EPP timeout interrupt onto the port interrupt.
// - Bits 3 and 4 pick divide by 13 or 12 per UART.
// - Read-only bit 5 shows floppy power-down state.
// - Read-only bit 6 shows floppy idle state regardless of mask.
// - Bit 7 masks idle pin low only when pin carries idle.
// - Identification register at 08h, chip code in bits 4 to 7.
// - Clocked modules stop their clock; unclocked ones lose access.
// - Chip power-down: oscillator stops or runs, pins float or drive.
// - Each module may be powered down individually in any mix.
// - Clocks return only with global power-down clear and enable set.
`ifndef POWER_PIN_CONFIG_DEFINES_VH
`define POWER_PIN_CONFIG_DEFINES_VH

// Configuration indices
`define IDX_POWER_PIN_CONTROL 8'h06
`define IDX_CLOCK_STATUS      8'h07
`define IDX_CHIP_ID           8'h08

// Power and pin control fields
`define PPC_IDE_FLOAT   0
`define PPC_FDC_FLOAT   1
`define PPC_UART_FLOAT  2
`define PPC_ECP_DMA     3
`define PPC_PIN_SELECT  4
`define PPC_SEL_LOCK    5
`define PPC_PP_FLOAT    6
`define PPC_RESET       8'h00

// Clock and status fields
`define CS_HALVE        0
`define CS_FDC_FAST     1
`define CS_EPP_TO_EN    2
`define CS_UART1_MIDI   3
`define CS_UART2_MIDI   4
`define CS_FDC_PD       5
`define CS_FDC_IDLE     6
`define CS_IDLE_MASK    7
`define CS_RESET        8'h00

// Baud prescaler divisors
`define DIV_STANDARD    4'hD
`define DIV_MIDI        4'hC

// Blocked input values
`define UART_BLOCKED    5'h1F
`define PP_BLOCKED      5'h13
`define READ_UNMAPPED   8'h00

`endif

/* File: design/clock_halver.v */
// Module clock enables derived from the master clock.
// Assumes one master clock; enables stay high unless halved to one cycle in two.
`timescale 1ns/1ns
module clock_halver
(
  // Clock and reset
  input  wire i_mclk,
  input  wire i_rst_n,
  // Control
  input  wire i_halve,
  input  wire i_fdc_fast,
  // Enables
  output wire o_module_en,
  output wire o_fdc_en
);

  reg phase_reg;

  // ==========================================================
  // Divide by two phase
  always @(posedge i_mclk)
  begin
    if (!i_rst_n)
      phase_reg <= 1'b0;
    else
      phase_reg <= ~phase_reg;
  end

  // Halved rate unless halving is off
  assign o_module_en = ~i_halve | phase_reg;
  // Floppy takes the full rate when fast mode and halving
  assign o_fdc_en    = o_module_en | (i_halve & i_fdc_fast);

endmodule // clock_halver

/* File: design/baud_prescaler.v */
// Baud generator input prescaler, divide by 13 or 12.
// Assumes i_tick is the module clock enable from the halver.
`timescale 1ns/1ns
`include "power_pin_config_defines.vh"
module baud_prescaler
#(
  parameter CW = 4
)
(
  // Clock and reset
  input  wire i_mclk,
  input  wire i_rst_n,
  // Control
  input  wire i_run,
  input  wire i_tick,
  input  wire i_midi,
  // Output pulse
  output reg  o_baud_en
);

  reg  [CW-1:0] count_reg;
  wire [CW-1:0] last;

  assign last = i_midi ? (`DIV_MIDI - 4'h1) : (`DIV_STANDARD - 4'h1);

  // ==========================================================
  // Count module ticks, pulse on wrap
  always @(posedge i_mclk)
  begin
    if (!i_rst_n || !i_run)
    begin
      count_reg <= {CW{1'b0}};
      o_baud_en <= 1'b0;
    end
    else
    begin
      o_baud_en <= 1'b0;
      if (i_tick)
      begin
        if (count_reg >= last)
        begin
          count_reg <= {CW{1'b0}};
          o_baud_en <= 1'b1;
        end
        else
          count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // baud_prescaler

/* File: design/power_pin_config.v */
// Power and pin control, clock/status and identification registers.
// Assumes the index/data configuration port decodes the index and
// gives one-cycle read and write strobes; other registers live elsewhere.
`timescale 1ns/1ns
`include "power_pin_config_defines.vh"
module power_pin_config
#(
  parameter [3:0] CHIP_CODE = 4'h5,  // Arbitrary value
  parameter       FDC_IN_W  = 4
)
(
  // Clock and reset
  input  wire                i_mclk,
  input  wire                i_rst_n,
  // Configuration port
  input  wire [7:0]          i_cfg_index,
  input  wire [7:0]          i_cfg_wdata,
  input  wire                i_cfg_wr,
  input  wire                i_cfg_rd,
  output reg  [7:0]          o_cfg_rdata,
  // Straps and other configuration bits
  input  wire                i_clk_halving_strap,
  input  wire                i_global_powerdown_bit,
  input  wire                i_global_lock,
  input  wire                i_osc_stop_select,
  input  wire                i_ide_enable,
  input  wire                i_fdc_enable,
  input  wire                i_uart1_enable,
  input  wire                i_uart2_enable,
  input  wire                i_pp_enable,
  input  wire                i_ecp_enable,
  input  wire                i_ecp_dma_enable,
  // Module status and signals
  input  wire                i_fdc_powerdown_state,
  input  wire                i_fdc_idle_state,
  input  wire                i_drive1_motor,
  input  wire                i_drive1_select,
  input  wire                i_epp_timeout,
  input  wire                i_ecp_dma_request,
  // Pins arriving from outside
  input  wire                i_ide_data_bit7,
  input  wire [FDC_IN_W-1:0] i_fdc_inputs,
  input  wire                i_disk_change_input,
  input  wire [4:0]          i_uart1_inputs,
  input  wire [4:0]          i_uart2_inputs,
  input  wire [4:0]          i_pp_inputs,
  input  wire                i_ecp_dma_acknowledge,
  // Pin enables and blocked inputs
  output reg                 o_ide_select_oe,
  output reg                 o_ide_data_bit7,
  output reg                 o_fdc_outputs_oe,
  output reg  [FDC_IN_W-1:0] o_fdc_inputs,
  output reg                 o_disk_change_input,
  output reg                 o_uart1_outputs_oe,
  output reg                 o_uart2_outputs_oe,
  output reg  [4:0]          o_uart1_inputs,
  output reg  [4:0]          o_uart2_inputs,
  output reg                 o_pp_outputs_oe,
  output reg  [4:0]          o_pp_inputs,
  output reg                 o_ecp_dma_acknowledge,
  output reg                 o_ecp_dma_request,
  output reg                 o_ecp_dma_request_oe,
  // Shared pins
  output reg                 o_pin_motor_or_idle,
  output reg                 o_pin_select_or_pd,
  output reg                 o_epp_timeout_irq,
  // Power and clocking
  output reg                 o_osc_run,
  output reg                 o_fdc_clk_en,
  output reg                 o_ecp_clk_en,
  output reg  [1:0]          o_uart_baud_en,
  output reg                 o_ide_access_en,
  output reg                 o_pp_access_en,
  output reg                 o_selective_lock
);

  // ==========================================================
  // Registers and decode
  reg  [7:0] ppc_reg;
  reg  [7:0] ppc_next;
  reg  [7:0] cs_reg;
  reg  [7:0] cs_next;
  reg  [7:0] rdata_next;
  wire       wr_ok;
  wire       chip_pd;
  wire       ide_down;
  wire       fdc_down;
  wire       pp_down;
  wire [1:0] uart_down;
  wire [1:0] uart_midi;
  wire [1:0] baud_pulse;
  wire       module_en;
  wire       fdc_en;

  // Index match for one strobe
  function hit;
    input [7:0] idx;
    input [7:0] want;
    begin
      hit = (idx == want);
    end
  endfunction

  // Global lock blocks every write, selective lock only some bits
  assign wr_ok     = i_cfg_wr & ~i_global_lock;

  // Each module powers down on its own or with the whole chip
  assign chip_pd   = i_global_powerdown_bit;
  assign ide_down  = chip_pd | ~i_ide_enable;
  assign fdc_down  = chip_pd | ~i_fdc_enable;
  assign pp_down   = chip_pd | ~i_pp_enable;
  assign uart_down = {chip_pd | ~i_uart2_enable,
                      chip_pd | ~i_uart1_enable};
  assign uart_midi = {cs_reg[`CS_UART2_MIDI], cs_reg[`CS_UART1_MIDI]};

  // ==========================================================
  // Power and pin control next value
  always @*
  begin
    ppc_next = ppc_reg;
    if (wr_ok && hit(i_cfg_index, `IDX_POWER_PIN_CONTROL))
    begin
      ppc_next = i_cfg_wdata;
      // Selective lock is set-only, and held once set
      ppc_next[`PPC_SEL_LOCK] = ppc_reg[`PPC_SEL_LOCK] |
                                i_cfg_wdata[`PPC_SEL_LOCK];
    end
  end

  // ==========================================================
  // Clock and status next value; bits 5 and 6 are not stored
  always @*
  begin
    cs_next = cs_reg;
    if (wr_ok && hit(i_cfg_index, `IDX_CLOCK_STATUS))
    begin
      cs_next[`CS_FDC_FAST]   = i_cfg_wdata[`CS_FDC_FAST];
      cs_next[`CS_EPP_TO_EN]  = i_cfg_wdata[`CS_EPP_TO_EN];
      cs_next[`CS_UART1_MIDI] = i_cfg_wdata[`CS_UART1_MIDI];
      cs_next[`CS_UART2_MIDI] = i_cfg_wdata[`CS_UART2_MIDI];
      cs_next[`CS_IDLE_MASK]  = i_cfg_wdata[`CS_IDLE_MASK];
      // Halving bit frozen by the selective lock
      if (!ppc_reg[`PPC_SEL_LOCK])
        cs_next[`CS_HALVE] = i_cfg_wdata[`CS_HALVE];
    end
    cs_next[`CS_FDC_PD]   = 1'b0;
    cs_next[`CS_FDC_IDLE] = 1'b0;
  end

  // ==========================================================
  // Register update; halving bit latches the strap during reset
  always @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      ppc_reg            <= `PPC_RESET;
      cs_reg             <= `CS_RESET;
      cs_reg[`CS_HALVE]  <= i_clk_halving_strap;
    end
    else
    begin
      ppc_reg <= ppc_next;
      cs_reg  <= cs_next;
    end
  end

  // ==========================================================
  // Read data mux; status bits are live
  always @*
  begin
    rdata_next = o_cfg_rdata;
    if (i_cfg_rd)
    begin
      if (hit(i_cfg_index, `IDX_POWER_PIN_CONTROL))
        rdata_next = ppc_reg;
      else if (hit(i_cfg_index, `IDX_CLOCK_STATUS))
      begin
        rdata_next = cs_reg;
        rdata_next[`CS_FDC_PD]   = i_fdc_powerdown_state;
        rdata_next[`CS_FDC_IDLE] = i_fdc_idle_state;
      end
      else if (hit(i_cfg_index, `IDX_CHIP_ID))
        rdata_next = {CHIP_CODE, 4'h0};
      else
        rdata_next = `READ_UNMAPPED;
    end
  end

  // ==========================================================
  // Clock enables and baud prescalers
  clock_halver u_halver
  (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_halve     (cs_reg[`CS_HALVE]),
    .i_fdc_fast  (cs_reg[`CS_FDC_FAST]),
    .o_module_en (module_en),
    .o_fdc_en    (fdc_en)
  );

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_baud
      baud_prescaler #(.CW(4)) u_pre
      (
        .i_mclk    (i_mclk),
        .i_rst_n   (i_rst_n),
        .i_run     (~uart_down[g]),
        .i_tick    (module_en),
        .i_midi    (uart_midi[g]),
        .o_baud_en (baud_pulse[g])
      );
    end
  endgenerate

  // ==========================================================
  // Registered outputs: pin gating, muxing and power state
  always @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_cfg_rdata           <= `READ_UNMAPPED;
      o_ide_select_oe       <= 1'b0;
      o_ide_data_bit7       <= 1'b0;
      o_fdc_outputs_oe      <= 1'b0;
      o_fdc_inputs          <= {FDC_IN_W{1'b0}};
      o_disk_change_input   <= 1'b0;
      o_uart1_outputs_oe    <= 1'b0;
      o_uart2_outputs_oe    <= 1'b0;
      o_uart1_inputs        <= `UART_BLOCKED;
      o_uart2_inputs        <= `UART_BLOCKED;
      o_pp_outputs_oe       <= 1'b0;
      o_pp_inputs           <= `PP_BLOCKED;
      o_ecp_dma_acknowledge <= 1'b1;
      o_ecp_dma_request     <= 1'b0;
      o_ecp_dma_request_oe  <= 1'b0;
      o_pin_motor_or_idle   <= 1'b0;
      o_pin_select_or_pd    <= 1'b0;
      o_epp_timeout_irq     <= 1'b0;
      o_osc_run             <= 1'b1;
      o_fdc_clk_en          <= 1'b0;
      o_ecp_clk_en          <= 1'b0;
      o_uart_baud_en        <= 2'b00;
      o_ide_access_en       <= 1'b0;
      o_pp_access_en        <= 1'b0;
      o_selective_lock      <= 1'b0;
    end
    else
    begin
      o_cfg_rdata <= rdata_next;
      // IDE chip selects float, data bit 7 blocked
      o_ide_select_oe <= ~(ppc_reg[`PPC_IDE_FLOAT] & ide_down);
      o_ide_data_bit7 <= (ppc_reg[`PPC_IDE_FLOAT] & ide_down) ?
                         1'b0 : i_ide_data_bit7;
      // Floppy outputs float, inputs blocked, disk change passes
      o_fdc_outputs_oe <= ~(ppc_reg[`PPC_FDC_FLOAT] & fdc_down);
      o_fdc_inputs     <= (ppc_reg[`PPC_FDC_FLOAT] & fdc_down) ?
                          {FDC_IN_W{1'b0}} : i_fdc_inputs;
      o_disk_change_input <= i_disk_change_input;
      // Each UART gated on its own power state
      o_uart1_outputs_oe <= ~(ppc_reg[`PPC_UART_FLOAT] & uart_down[0]);
      o_uart2_outputs_oe <= ~(ppc_reg[`PPC_UART_FLOAT] & uart_down[1]);
      o_uart1_inputs <= (ppc_reg[`PPC_UART_FLOAT] & uart_down[0]) ?
                        `UART_BLOCKED : i_uart1_inputs;
      o_uart2_inputs <= (ppc_reg[`PPC_UART_FLOAT] & uart_down[1]) ?
                        `UART_BLOCKED : i_uart2_inputs;
      // Parallel port float and fixed blocked inputs
      o_pp_outputs_oe <= ~(ppc_reg[`PPC_PP_FLOAT] & pp_down);
      o_pp_inputs     <= (ppc_reg[`PPC_PP_FLOAT] & pp_down) ?
                         `PP_BLOCKED : i_pp_inputs;
      // ECP DMA pins only when configured
      o_ecp_dma_acknowledge <= ppc_reg[`PPC_ECP_DMA] ?
                               i_ecp_dma_acknowledge : 1'b1;
      o_ecp_dma_request     <= i_ecp_dma_request;
      o_ecp_dma_request_oe  <= ppc_reg[`PPC_ECP_DMA] &
                               i_ecp_dma_enable;
      // Shared pins: drive 1 or idle / power-down indication
      if (ppc_reg[`PPC_PIN_SELECT])
      begin
        o_pin_motor_or_idle <= cs_reg[`CS_IDLE_MASK] ?
                               1'b0 : i_fdc_idle_state;
        o_pin_select_or_pd  <= i_fdc_powerdown_state;
      end
      else
      begin
        o_pin_motor_or_idle <= i_drive1_motor;
        o_pin_select_or_pd  <= i_drive1_select;
      end
      o_epp_timeout_irq <= cs_reg[`CS_EPP_TO_EN] & i_epp_timeout;
      // Whole-chip power-down: oscillator stop chosen separately
      o_osc_run    <= ~(chip_pd & i_osc_stop_select);
      // Clocks return only when global power-down clear and enabled
      o_fdc_clk_en <= fdc_en & ~fdc_down & ~chip_pd;
      o_ecp_clk_en <= module_en & ~chip_pd & i_ecp_enable &
                      i_pp_enable;
      o_uart_baud_en  <= baud_pulse;
      o_ide_access_en <= ~ide_down;
      o_pp_access_en  <= ~pp_down;
      o_selective_lock <= ppc_reg[`PPC_SEL_LOCK];
    end
  end

endmodule // power_pin_config

/* File: sim/power_pin_config_properties.sv */
// Checker for the power and pin control register bank.
// Assumes it is bound to power_pin_config and sees only its ports.
`timescale 1ns/1ns
module power_pin_config_props
#(
  parameter [3:0] CHIP_CODE = 4'h5
)
(
  // Clock, reset and configuration port
  input wire       i_mclk,
  input wire       i_rst_n,
  input wire [7:0] i_cfg_index,
  input wire       i_cfg_rd,
  input wire [7:0] o_cfg_rdata,
  // Controls and raw pins
  input wire       i_global_powerdown_bit,
  input wire       i_osc_stop_select,
  input wire       i_ide_enable,
  input wire       i_disk_change_input,
  input wire       i_epp_timeout,
  // Observed outputs
  input wire       o_ide_select_oe,
  input wire       o_disk_change_input,
  input wire       o_uart1_outputs_oe,
  input wire [4:0] o_uart1_inputs,
  input wire       o_pp_outputs_oe,
  input wire [4:0] o_pp_inputs,
  input wire       o_epp_timeout_irq,
  input wire       o_osc_run,
  input wire [1:0] o_uart_baud_en,
  input wire       o_selective_lock
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // Properties
  sequence s_baud_quiet;
    !o_uart_baud_en[0] [*8];
  endsequence
  property p_baud_gap;
    o_uart_baud_en[0] |=> s_baud_quiet;
  endproperty
  property p_ide_float;
    !o_ide_select_oe && $past(i_rst_n)
      |-> !$past(i_ide_enable) || $past(i_global_powerdown_bit);
  endproperty
  property p_uart_block;
    !o_uart1_outputs_oe |-> o_uart1_inputs == 5'h1F;
  endproperty
  property p_pp_block;
    !o_pp_outputs_oe |-> o_pp_inputs == 5'h13;
  endproperty
  property p_disk_change;
    $past(i_rst_n) |-> o_disk_change_input == $past(i_disk_change_input);
  endproperty
  property p_lock_sticky;
    o_selective_lock |=> o_selective_lock;
  endproperty
  property p_epp_irq;
    o_epp_timeout_irq |-> $past(i_epp_timeout);
  endproperty
  property p_chip_id;
    i_cfg_rd && i_cfg_index == 8'h08 |=> o_cfg_rdata[7:4] == CHIP_CODE;
  endproperty
  property p_osc_stop;
    $past(i_rst_n && i_global_powerdown_bit && i_osc_stop_select)
      |-> !o_osc_run;
  endproperty
  a_baud_gap: assert property (p_baud_gap)
    else $error("baud pulses too close");
  a_ide_float: assert property (p_ide_float)
    else $error("ide selects floated while enabled");
  a_uart_block: assert property (p_uart_block)
    else $error("uart inputs not blocked high");
  a_pp_block: assert property (p_pp_block)
    else $error("parallel inputs not at blocked values");
  a_disk_change: assert property (p_disk_change)
    else $error("disk change input not passed");
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("selective lock cleared");
  a_epp_irq: assert property (p_epp_irq)
    else $error("timeout interrupt without event");
  a_chip_id: assert property (p_chip_id)
    else $error("identification code wrong");
  a_osc_stop: assert property (p_osc_stop)
    else $error("oscillator runs in stop mode");
endmodule // power_pin_config_props

bind power_pin_config power_pin_config_props
  #(.CHIP_CODE(CHIP_CODE)) chk_u (.*);

/* File: sim/host_model.sv */
// Host side of the index/data configuration port.
// Assumes the bench calls its tasks; strobes last one clock.
`timescale 1ns/1ns
module host_model
(
  // Clock
  input  wire       i_mclk,
  // Configuration port
  output reg  [7:0] o_cfg_index,
  output reg  [7:0] o_cfg_wdata,
  output reg        o_cfg_wr,
  output reg        o_cfg_rd,
  input  wire [7:0] i_cfg_rdata
);
  // Idle port: unmapped index, strobes low
  initial
  begin
    {o_cfg_index, o_cfg_wdata, o_cfg_wr, o_cfg_rd} = 18'h3FC00;
  end
  // One write strobe, data held across the sampling edge
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge i_mclk);
      #1;
      {o_cfg_index, o_cfg_wdata, o_cfg_wr} = {a, d, 1'b1};
      @(posedge i_mclk);
      #1;
      {o_cfg_index, o_cfg_wdata, o_cfg_wr} = {8'hFF, ~d, 1'b0};
    end
  endtask
  // One read strobe; data is registered at the sampling edge
  task rd(input [7:0] a, output [7:0] q);
    begin
      @(posedge i_mclk);
      #1;
      {o_cfg_index, o_cfg_rd} = {a, 1'b1};
      @(posedge i_mclk);
      #1;
      q = i_cfg_rdata;
      {o_cfg_index, o_cfg_rd} = {8'hFF, 1'b0};
    end
  endtask
  // Update keeps unnamed bits such as bit 7 as read
  task rmw(input [7:0] a, input [7:0] set, input [7:0] clr);
    reg [7:0] q;
    begin
      rd(a, q);
      wr(a, (q & ~clr) | set);
    end
  endtask
endmodule // host_model

/* File: sim/test_power_pin_config.sv */
// Self-checking bench for the power and pin control register bank.
// Assumes the host model drives the port; pins come from bench regs.
`timescale 1ns/1ns
`define CHK(a, b) \
  begin \
    check_count = check_count + 1; \
    if ((a) !== (b)) \
    begin \
      n_errors = n_errors + 1; \
      $display("BAD t=%0t got %h exp %h", $time, a, b); \
    end \
  end
module test_power_pin_config;
  reg i_mclk, i_rst_n, i_clk_halving_strap, i_global_powerdown_bit;
  reg i_global_lock, i_osc_stop_select, i_ide_enable, i_fdc_enable;
  reg i_uart1_enable, i_uart2_enable, i_pp_enable, i_ecp_enable;
  reg i_ecp_dma_enable, i_fdc_powerdown_state, i_fdc_idle_state;
  reg i_drive1_motor, i_drive1_select, i_epp_timeout, i_ecp_dma_request;
  reg i_ide_data_bit7, i_disk_change_input, i_ecp_dma_acknowledge;
  reg [3:0] i_fdc_inputs;
  reg [4:0] i_uart1_inputs, i_uart2_inputs, i_pp_inputs;
  wire [7:0] i_cfg_index, i_cfg_wdata, o_cfg_rdata;
  wire i_cfg_wr, i_cfg_rd, o_ide_select_oe, o_ide_data_bit7;
  wire o_fdc_outputs_oe, o_disk_change_input, o_uart1_outputs_oe;
  wire o_uart2_outputs_oe, o_pp_outputs_oe, o_ecp_dma_acknowledge;
  wire o_ecp_dma_request, o_ecp_dma_request_oe, o_pin_motor_or_idle;
  wire o_pin_select_or_pd, o_epp_timeout_irq, o_osc_run, o_fdc_clk_en;
  wire o_ecp_clk_en, o_ide_access_en, o_pp_access_en, o_selective_lock;
  wire [3:0] o_fdc_inputs;
  wire [4:0] o_uart1_inputs, o_uart2_inputs, o_pp_inputs;
  wire [1:0] o_uart_baud_en;
  integer n_errors, check_count, k, n;
  reg [7:0] q;
  reg [14:0] rows [0:5];

  power_pin_config dut_u (.*);
  host_model host_u (.i_mclk(i_mclk), .o_cfg_index(i_cfg_index),
    .o_cfg_wdata(i_cfg_wdata), .o_cfg_wr(i_cfg_wr),
    .o_cfg_rd(i_cfg_rd), .i_cfg_rdata(o_cfg_rdata));

  // ==========================================================
  // Clock and helpers
  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  task step(input integer c);
    begin
      repeat (c) @(posedge i_mclk);
      #1;
    end
  endtask
  // Clocks between two baud pulses of one UART
  task gap(input integer b, output integer c);
    integer w;
    begin
      w = 0;
      while (o_uart_baud_en[b] !== 1'b1 && w < 100)
      begin
        step(1);
        w = w + 1;
      end
      step(1);
      c = 1;
      while (o_uart_baud_en[b] !== 1'b1 && c < 100)
      begin
        step(1);
        c = c + 1;
      end
    end
  endtask
  // Floppy clock enables seen in 24 clocks
  task fcount(output integer c);
    begin
      c = 0;
      repeat (24)
      begin
        step(1);
        c = c + (o_fdc_clk_en === 1'b1);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Watchdog well past the expected run length
  initial
  begin
    #400000;
    n_errors = n_errors + 1;
    conclude;
  end

  // ==========================================================
  // Tests
  initial
  begin
    // Rows: ppc, ide/pp/uart1 enable, power-down, expected enables
    rows[0] = {8'h00, 4'b1110, 3'b111};
    rows[1] = {8'h00, 4'b0000, 3'b111};
    rows[2] = {8'h47, 4'b0110, 3'b011};
    rows[3] = {8'h47, 4'b1000, 3'b100};
    rows[4] = {8'h47, 4'b1111, 3'b000};
    rows[5] = {8'h47, 4'b1110, 3'b111};
    n_errors = 0;
    check_count = 0;
    {i_rst_n, i_clk_halving_strap, i_global_powerdown_bit} = 3'b010;
    {i_global_lock, i_osc_stop_select, i_ide_enable} = 3'b011;
    {i_fdc_enable, i_uart1_enable, i_uart2_enable, i_pp_enable} = 4'hF;
    {i_ecp_enable, i_ecp_dma_enable, i_fdc_powerdown_state} = 3'b110;
    {i_fdc_idle_state, i_drive1_motor, i_drive1_select} = 3'b110;
    {i_epp_timeout, i_ecp_dma_request, i_ide_data_bit7} = 3'b111;
    {i_disk_change_input, i_ecp_dma_acknowledge} = 2'b10;
    {i_fdc_inputs, i_uart1_inputs} = {4'hA, 5'h0A};
    {i_uart2_inputs, i_pp_inputs} = {5'h0A, 5'h0C};
    step(16);
    i_rst_n = 1'b1;
    host_u.rd(8'h06, q);
    `CHK(q, 8'h00)
    host_u.rd(8'h07, q);
    `CHK(q, 8'h41)
    host_u.rd(8'h08, q);
    `CHK(q, 8'h50)
    host_u.rd(8'h09, q);
    `CHK(q, 8'h00)
    $display("test reset done");
    for (k = 0; k < 6; k = k + 1)
    begin
      host_u.wr(8'h06, rows[k][14:7]);
      {i_ide_enable, i_pp_enable, i_uart1_enable} = rows[k][6:4];
      i_global_powerdown_bit = rows[k][3];
      step(2);
      `CHK(o_ide_select_oe, rows[k][2])
      `CHK(o_ide_data_bit7, rows[k][2])
      `CHK(o_pp_outputs_oe, rows[k][1])
      `CHK(o_pp_inputs, rows[k][1] ? 5'h0C : 5'h13)
      `CHK(o_uart1_outputs_oe, rows[k][0])
      `CHK(o_uart1_inputs, rows[k][0] ? 5'h0A : 5'h1F)
      `CHK(o_ide_access_en, rows[k][6] & ~rows[k][3])
      `CHK(o_pp_access_en, rows[k][5] & ~rows[k][3])
      `CHK(o_fdc_outputs_oe, !(rows[k][8] & rows[k][3]))
      `CHK(o_fdc_inputs, (rows[k][8] & rows[k][3]) ? 4'h0 : 4'hA)
      `CHK(o_uart2_outputs_oe, !(rows[k][9] & rows[k][3]))
      `CHK(o_uart2_inputs, (rows[k][9] & rows[k][3]) ? 5'h1F : 5'h0A)
    end
    {i_ide_enable, i_pp_enable, i_uart1_enable} = 3'b111;
    i_global_powerdown_bit = 1'b0;
    $display("test rows done");
    // Clock, prescaler and status bits
    host_u.wr(8'h07, 8'hEE);
    host_u.rd(8'h07, q);
    `CHK(q, 8'hCE)
    gap(0, n);
    `CHK(n, 12)
    gap(1, n);
    `CHK(n, 13)
    host_u.wr(8'h07, 8'hFF);
    gap(0, n);
    `CHK(n, 24)
    fcount(n);
    `CHK(n, 24)
    `CHK(o_epp_timeout_irq, 1'b1)
    host_u.wr(8'h07, 8'hF9);
    fcount(n);
    `CHK(n, 12)
    `CHK(o_epp_timeout_irq, 1'b0)
    {i_global_powerdown_bit, i_osc_stop_select} = 2'b11;
    fcount(n);
    `CHK(n, 0)
    `CHK(o_ecp_clk_en, 1'b0)
    `CHK(o_osc_run, 1'b0)
    i_osc_stop_select = 1'b0;
    step(2);
    `CHK(o_osc_run, 1'b1)
    i_global_powerdown_bit = 1'b0;
    $display("test clocks done");
    // Shared pins and DMA pins
    step(1);
    `CHK({o_pin_motor_or_idle, o_pin_select_or_pd}, 2'b10)
    `CHK({o_ecp_dma_acknowledge, o_ecp_dma_request_oe}, 2'b10)
    i_fdc_powerdown_state = 1'b1;
    host_u.rmw(8'h06, 8'h18, 8'h00);
    step(2);
    `CHK({o_pin_motor_or_idle, o_pin_select_or_pd}, 2'b01)
    `CHK({o_ecp_dma_acknowledge, o_ecp_dma_request_oe}, 2'b01)
    `CHK(o_ecp_dma_request, 1'b1)
    host_u.wr(8'h07, 8'h79);
    host_u.rd(8'h07, q);
    `CHK(q, 8'h79)
    step(1);
    `CHK(o_pin_motor_or_idle, 1'b1)
    $display("test pins done");
    // Selective and global lock
    host_u.wr(8'h06, 8'h20);
    step(2);
    `CHK(o_selective_lock, 1'b1)
    host_u.wr(8'h06, 8'h01);
    host_u.rd(8'h06, q);
    `CHK(q, 8'h21)
    host_u.wr(8'h07, 8'h78);
    host_u.rd(8'h07, q);
    `CHK(q, 8'h79)
    i_global_lock = 1'b1;
    host_u.wr(8'h06, 8'h00);
    host_u.rd(8'h06, q);
    `CHK(q, 8'h21)
    i_rst_n = 1'b0;
    step(2);
    {i_rst_n, i_global_lock} = 2'b10;
    step(2);
    `CHK(o_selective_lock, 1'b0)
    $display("test lock done");
    conclude;
  end
endmodule // test_power_pin_config
